// ### design/vision_cmd_parser.sv
// Functional notes
// - 8N1 async serial, 1200..115200 baud
// - no flow control on link
// - ascii decimal digits, one byte each
// - good command answered with ACK
// - bad or errored command gets negative reply
// - carriage return follows either reply
// - idle prompt is CR then colon
// - white space splits arguments
// - CR ends line, starts execution
// - lone CR in idle: ACK CR CR colon
// - lone CR stops streaming, back idle
// - hold off: buffer keeps taking frames
// - hold on: frozen frame reused
// - fetch under hold grabs one frame
// - hold off needs no fetch
// - optional binary transfer setting
// - baud from three jumpers at reset
`timescale 1ns/10ps
module vision_cmd_parser
    import cmd_link_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [JMP_W-1:0] baud_jmp_in,
    input wire logic stream_req_in,
    input wire logic frame_ready_in,
    serial_link_if.dev link,
    output logic frame_capture_out,
    output logic frame_hold_out,
    output logic binary_mode_out,
    output logic streaming_out
);
    typedef enum {S_STRAP, S_PROMPT, S_IDLE, S_EXEC, S_REPLY} st_t;
    typedef struct packed {
        st_t st;
        logic [DIV_W-1:0] div;
        // receiver
        logic rx_busy;
        logic [DIV_W-1:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        // transmitter
        logic tx_busy;
        logic [DIV_W-1:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tx_line;
        // parser
        logic [7:0] c0;
        logic [7:0] c1;
        logic [2:0] nchar;
        logic [2:0] nargs;
        logic [7:0] arg;
        logic in_arg;
        logic err;
        logic nak;
        logic [2:0] rp;
        // modes
        logic hold;
        logic binary;
        logic stream;
        logic fetch_pend;
        logic capture;
    } state_t;
    state_t q_ff, nxt_q;

    function automatic logic is_ws(input logic [7:0] c);
        return (c == CH_SPACE) || (c == CH_TAB);
    endfunction
    function automatic logic is_dig(input logic [7:0] c);
        return (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction

    // ****************
    // reply text
    // ****************
    function automatic logic [7:0] reply_ch(input logic nak, input logic [2:0] i);
        case (i)
            3'h0: return nak ? CH_N : CH_A;
            3'h1: return nak ? CH_C : CH_C;
            3'h2: return CH_K;
            3'h3: return CH_CR;
            3'h4: return CH_CR;
            default: return CH_COLON;
        endcase
    endfunction

    logic rx_done;
    logic [7:0] rx_byte;
    logic tx_ready;

    always_comb
    begin
        nxt_q = q_ff;
        rx_done = 1'b0;
        rx_byte = q_ff.rx_sh;
        tx_ready = !q_ff.tx_busy;
        nxt_q.capture = 1'b0;
        if (!q_ff.rx_busy)
        begin
            if (!link.to_dev && q_ff.st != S_STRAP)
            begin
                nxt_q.rx_busy = 1'b1;
                nxt_q.rx_cnt = q_ff.div >> 1;
                nxt_q.rx_bit = 4'h0;
            end
        end
        else if (q_ff.rx_cnt != '0)
            nxt_q.rx_cnt = q_ff.rx_cnt - DIV_W'(1);
        else
        begin
            nxt_q.rx_cnt = q_ff.div;
            nxt_q.rx_bit = q_ff.rx_bit + 4'h1;
            if (q_ff.rx_bit == 4'h0 && link.to_dev)
                nxt_q.rx_busy = 1'b0;
            else if (q_ff.rx_bit >= 4'h1 && q_ff.rx_bit <= 4'(DATA_BITS))
                nxt_q.rx_sh = {link.to_dev, q_ff.rx_sh[7:1]};
            else if (q_ff.rx_bit > 4'(DATA_BITS))
            begin
                nxt_q.rx_busy = 1'b0;
                rx_done = 1'b1;
                if (!link.to_dev)
                    nxt_q.err = 1'b1;
            end
        end
        if (q_ff.tx_busy)
        begin
            if (q_ff.tx_cnt != '0)
                nxt_q.tx_cnt = q_ff.tx_cnt - DIV_W'(1);
            else
            begin
                nxt_q.tx_cnt = q_ff.div;
                nxt_q.tx_line = q_ff.tx_sh[0];
                nxt_q.tx_sh = {1'b1, q_ff.tx_sh[9:1]};
                nxt_q.tx_bit = q_ff.tx_bit + 4'h1;
                if (q_ff.tx_bit == 4'(DATA_BITS + 1))
                    nxt_q.tx_busy = 1'b0;
            end
        end
        if (frame_ready_in && (!q_ff.hold || q_ff.fetch_pend))
        begin
            nxt_q.capture = 1'b1;
            nxt_q.fetch_pend = 1'b0;
        end
        case (q_ff.st)
            S_STRAP:
            begin
                nxt_q.div = baud_div(baud_jmp_in);
                nxt_q.st = S_PROMPT;
                nxt_q.rp = 3'h4;
            end
            S_IDLE:
                if (rx_done)
                begin
                    if (rx_byte == CH_CR)
                        nxt_q.st = S_EXEC;
                    else if (is_ws(rx_byte))
                        nxt_q.in_arg = 1'b0;
                    else if (q_ff.nchar < 3'h2 && q_ff.nargs == 3'h0)
                    begin
                        nxt_q.nchar = q_ff.nchar + 3'h1;
                        if (q_ff.nchar == 3'h0)
                            nxt_q.c0 = rx_byte;
                        else
                            nxt_q.c1 = rx_byte;
                    end
                    else if (q_ff.nchar == 3'h2 && !q_ff.in_arg && is_dig(rx_byte))
                    begin
                        nxt_q.in_arg = 1'b1;
                        nxt_q.nargs = q_ff.nargs + 3'h1;
                        nxt_q.arg = rx_byte;
                    end
                    else if (q_ff.in_arg && is_dig(rx_byte))
                        nxt_q.arg = rx_byte;
                    else
                        nxt_q.err = 1'b1;
                end
            S_EXEC:
            begin
                nxt_q.nak = 1'b0;
                nxt_q.rp = 3'h0;
                nxt_q.st = S_REPLY;
                if (q_ff.err)
                    nxt_q.nak = 1'b1;
                else if (q_ff.nchar == 3'h0)
                    nxt_q.stream = 1'b0;
                else if (q_ff.c0 == CH_B && q_ff.c1 == CH_M && q_ff.nargs == 3'h1)
                    nxt_q.hold = q_ff.arg[0];
                else if (q_ff.c0 == CH_R && q_ff.c1 == CH_M && q_ff.nargs == 3'h1)
                    nxt_q.binary = q_ff.arg[0];
                else if (q_ff.c0 == CH_R && q_ff.c1 == CH_F && q_ff.nargs == 3'h0)
                    nxt_q.fetch_pend = q_ff.hold;
                else
                    nxt_q.nak = 1'b1;
            end
            S_REPLY, S_PROMPT:
                if (tx_ready)
                begin
                    nxt_q.tx_busy = 1'b1;
                    nxt_q.tx_cnt = q_ff.div;
                    nxt_q.tx_bit = 4'h0;
                    nxt_q.tx_sh = {1'b1, reply_ch(q_ff.nak, q_ff.rp), 1'b0};
                    nxt_q.rp = q_ff.rp + 3'h1;
                    if (q_ff.rp == 3'h5)
                    begin
                        nxt_q.st = S_IDLE;
                        nxt_q.nchar = 3'h0;
                        nxt_q.nargs = 3'h0;
                        nxt_q.in_arg = 1'b0;
                        nxt_q.err = 1'b0;
                    end
                end
            default:
                nxt_q.st = S_STRAP;
        endcase
        if (stream_req_in)
            nxt_q.stream = 1'b1;
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            q_ff <= '0;
            q_ff.st <= S_STRAP;
            q_ff.tx_line <= 1'b1;
        end
        else
            q_ff <= nxt_q;
    end

    assign link.to_host = q_ff.tx_line;
    assign frame_capture_out = q_ff.capture;
    assign frame_hold_out = q_ff.hold;
    assign binary_mode_out = q_ff.binary;
    assign streaming_out = q_ff.stream;
endmodule // vision_cmd_parser

// ### design/cmd_link_pkg.sv
package cmd_link_pkg;
    // ****************
    // timing
    // ****************
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned BAUD_MAX = 115200;
    localparam int unsigned BAUD_MIN = 1200;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned DIV_W = 16;
    // ****************
    // characters
    // ****************
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_TAB = 8'h09;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_C = 8'h43;
    localparam logic [7:0] CH_K = 8'h4B;
    localparam logic [7:0] CH_N = 8'h4E;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_B = 8'h42;
    localparam logic [7:0] CH_M = 8'h4D;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_F = 8'h46;
    // ****************
    // baud jumpers
    // ****************
    localparam int unsigned JMP_W = 3;
    function automatic logic [DIV_W-1:0] baud_div(input logic [JMP_W-1:0] jmp);
        int unsigned rate;
        rate = BAUD_MAX >> jmp;
        if (jmp == 3'h7)
            rate = BAUD_MIN;
        return DIV_W'(CLK_HZ / rate);
    endfunction
endpackage

// ### design/serial_link_if.sv
`timescale 1ns/10ps
interface serial_link_if;
    logic to_dev;
    logic to_host;
    modport dev (input to_dev, output to_host);
    modport host (output to_dev, input to_host);
endinterface

// ### design/vision_cmd_host.sv
`timescale 1ns/10ps
module vision_cmd_host
    import cmd_link_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [DIV_W-1:0] baud_div_in,
    input wire logic send_valid_in,
    input wire logic [7:0] send_byte_in,
    serial_link_if.host link,
    output logic send_ready_out,
    output logic recv_valid_out,
    output logic [7:0] recv_byte_out,
    output logic prompt_seen_out
);
    typedef struct packed {
        logic tx_busy;
        logic [DIV_W-1:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tx_line;
        logic rx_busy;
        logic [DIV_W-1:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rv;
        logic [7:0] rb;
        logic last_cr;
        logic prompt;
    } hstate_t;
    hstate_t q_ff, nxt_q;

    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.rv = 1'b0;
        if (!q_ff.tx_busy)
        begin
            if (send_valid_in && q_ff.prompt)
            begin
                nxt_q.tx_busy = 1'b1;
                nxt_q.tx_cnt = baud_div_in;
                nxt_q.tx_bit = 4'h0;
                nxt_q.tx_sh = {1'b1, send_byte_in, 1'b0};
                if (send_byte_in == CH_CR)
                    nxt_q.prompt = 1'b0;
            end
        end
        else if (q_ff.tx_cnt != '0)
            nxt_q.tx_cnt = q_ff.tx_cnt - DIV_W'(1);
        else
        begin
            nxt_q.tx_cnt = baud_div_in;
            nxt_q.tx_line = q_ff.tx_sh[0];
            nxt_q.tx_sh = {1'b1, q_ff.tx_sh[9:1]};
            nxt_q.tx_bit = q_ff.tx_bit + 4'h1;
            if (q_ff.tx_bit == 4'(DATA_BITS + 1))
                nxt_q.tx_busy = 1'b0;
        end
        if (!q_ff.rx_busy)
        begin
            if (!link.to_host)
            begin
                nxt_q.rx_busy = 1'b1;
                nxt_q.rx_cnt = baud_div_in >> 1;
                nxt_q.rx_bit = 4'h0;
            end
        end
        else if (q_ff.rx_cnt != '0)
            nxt_q.rx_cnt = q_ff.rx_cnt - DIV_W'(1);
        else
        begin
            nxt_q.rx_cnt = baud_div_in;
            nxt_q.rx_bit = q_ff.rx_bit + 4'h1;
            if (q_ff.rx_bit == 4'h0 && link.to_host)
                nxt_q.rx_busy = 1'b0;
            else if (q_ff.rx_bit <= 4'(DATA_BITS) && q_ff.rx_bit >= 4'h1)
                nxt_q.rx_sh = {link.to_host, q_ff.rx_sh[7:1]};
            else if (q_ff.rx_bit > 4'(DATA_BITS))
            begin
                nxt_q.rx_busy = 1'b0;
                nxt_q.rv = 1'b1;
                nxt_q.rb = q_ff.rx_sh;
                nxt_q.last_cr = (q_ff.rx_sh == CH_CR);
                if (q_ff.last_cr && q_ff.rx_sh == CH_COLON)
                    nxt_q.prompt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            q_ff <= '0;
            q_ff.tx_line <= 1'b1;
        end
        else
            q_ff <= nxt_q;
    end

    assign link.to_dev = q_ff.tx_line;
    assign send_ready_out = !q_ff.tx_busy && q_ff.prompt;
    assign recv_valid_out = q_ff.rv;
    assign recv_byte_out = q_ff.rb;
    assign prompt_seen_out = q_ff.prompt;
endmodule // vision_cmd_host

// ### verif/vision_link_assertions.sv
`timescale 1ns/10ps
// ****************
// byte tap
// ****************
module link_byte_tap
#(parameter int BIT = 218)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic line_in,
    output logic samp_out,
    output logic [3:0] idx_out,
    output logic done_out,
    output logic [7:0] byte_out,
    output logic [7:0] prev_out
);
    logic busy_ff;
    logic [15:0] cnt_ff;
    logic [7:0] sh_ff;
    // mid-bit sampling tolerates a cycle of drift per bit
    assign samp_out = busy_ff && (cnt_ff == 16'(BIT / 2));
    always_ff @(posedge mclk_in)
    begin
        done_out <= 1'b0;
        if (rst_in)
        begin
            busy_ff <= 1'b0;
            idx_out <= 4'h0;
            byte_out <= 8'h00;
            prev_out <= 8'h00;
        end
        else if (!busy_ff)
        begin
            busy_ff <= !line_in;
            cnt_ff <= 16'h0001;
            idx_out <= 4'h0;
        end
        else
        begin
            cnt_ff <= (cnt_ff == 16'(BIT - 1)) ? 16'h0000 : cnt_ff + 16'h0001;
            if (samp_out)
            begin
                sh_ff <= {line_in, sh_ff[7:1]};
                idx_out <= idx_out + 4'h1;
                if (idx_out == 4'h9)
                begin
                    busy_ff <= 1'b0;
                    done_out <= 1'b1;
                    byte_out <= sh_ff;
                    prev_out <= byte_out;
                end
            end
        end
    end
endmodule // link_byte_tap

// ****************
// link checker
// ****************
module vision_link_assertions
    import cmd_link_pkg::*;
#(parameter int BIT = 218)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic to_dev_in,
    input wire logic to_host_in
);
    logic t_samp, t_done, r_done;
    logic [3:0] t_idx;
    logic [7:0] t_byte, t_prev, r_byte;
    link_byte_tap #(.BIT(BIT)) tx_tap (.mclk_in(mclk_in), .rst_in(rst_in),
        .line_in(to_host_in), .samp_out(t_samp), .idx_out(t_idx), .done_out(t_done),
        .byte_out(t_byte), .prev_out(t_prev));
    link_byte_tap #(.BIT(BIT)) rx_tap (.mclk_in(mclk_in), .rst_in(rst_in),
        .line_in(to_dev_in), .samp_out(), .idx_out(), .done_out(r_done),
        .byte_out(r_byte), .prev_out());
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    property p_start_low;
        t_samp && t_idx == 4'h0 |-> !to_host_in;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit high");
    property p_stop_high;
        t_samp && t_idx == 4'h9 |-> to_host_in;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit low");
    property p_reply_tail;
        t_done && t_byte == CH_K |-> t_prev == CH_C;
    endproperty
    a_reply_tail: assert property (p_reply_tail) else $error("bad reply tail");
    property p_reply_head;
        t_done && t_byte == CH_C |-> t_prev == CH_A || t_prev == CH_N;
    endproperty
    a_reply_head: assert property (p_reply_head) else $error("bad reply head");
    property p_cr_after;
        t_done && t_prev == CH_K |-> t_byte == CH_CR;
    endproperty
    a_cr_after: assert property (p_cr_after) else $error("no cr after reply");
    property p_cr_soon;
        t_done && t_byte == CH_K |-> ##[1:300] !to_host_in;
    endproperty
    a_cr_soon: assert property (p_cr_soon) else $error("gap after reply");
    property p_prompt;
        t_done && t_byte == CH_COLON |-> t_prev == CH_CR;
    endproperty
    a_prompt: assert property (p_prompt) else $error("colon without cr");
    property p_idle;
        t_done && t_byte == CH_COLON |=> to_host_in [*8];
    endproperty
    a_idle: assert property (p_idle) else $error("line busy after prompt");
    property p_boot;
        $fell(rst_in) |-> ##[1:300] !to_host_in;
    endproperty
    a_boot: assert property (p_boot) else $error("no prompt after reset");
    property p_exec;
        r_done && r_byte == CH_CR |-> ##[1:300] !to_host_in;
    endproperty
    a_exec: assert property (p_exec) else $error("no reply to cr");
endmodule // vision_link_assertions

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import cmd_link_pkg::*;
    localparam int LIM = 6000;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic stream_req = 1'b0;
    logic frame_ready = 1'b0;
    logic send_valid = 1'b0;
    logic [7:0] send_byte = 8'h00;
    logic capture, hold, binary, streaming, send_ready, recv_valid, prompt_seen;
    logic [7:0] recv_byte;
    int n_fail = 0;
    int n_tests = 0;
    serial_link_if serial_link_if_inst ();
    vision_cmd_parser vision_cmd_parser_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .baud_jmp_in(3'h0), .stream_req_in(stream_req), .frame_ready_in(frame_ready),
        .link(serial_link_if_inst.dev), .frame_capture_out(capture),
        .frame_hold_out(hold), .binary_mode_out(binary), .streaming_out(streaming));
    // divisor 217 (218 clocks per bit) matches the all-open jumper rate
    vision_cmd_host vision_cmd_host_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .baud_div_in(16'h00D9), .send_valid_in(send_valid), .send_byte_in(send_byte),
        .link(serial_link_if_inst.host), .send_ready_out(send_ready),
        .recv_valid_out(recv_valid), .recv_byte_out(recv_byte),
        .prompt_seen_out(prompt_seen));
    vision_link_assertions #(.BIT(218)) vision_link_assertions_inst (.mclk_in(mclk_in),
        .rst_in(rst_in), .to_dev_in(serial_link_if_inst.to_dev),
        .to_host_in(serial_link_if_inst.to_host));
    initial
    begin
        forever #20 mclk_in = ~mclk_in;
    end
    // ****************
    // tasks
    // ****************
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hang(input string what);
        n_fail++;
        $display("MISMATCH %s expected done seen timeout", what);
        finish_test();
    endtask
    task automatic put(input logic [7:0] b);
        int i;
        logic r;
        i = 0;
        @(posedge mclk_in);
        send_valid <= 1'b1;
        send_byte <= b;
        do
        begin
            @(negedge mclk_in);
            r = send_ready;
            @(posedge mclk_in);
            i++;
        end
        while (r !== 1'b1 && i < LIM);
        send_valid <= 1'b0;
        if (r !== 1'b1)
            hang("send");
    endtask
    task automatic get(input logic [7:0] exp);
        int i;
        i = 0;
        do
        begin
            @(negedge mclk_in);
            i++;
        end
        while (recv_valid !== 1'b1 && i < LIM);
        if (recv_valid !== 1'b1)
            hang("reply");
        check("reply", recv_byte, exp);
    endtask
    // no flow control, so each line waits for the full prompt
    // line text packed first byte highest, n bytes of it sent
    task automatic cmd(input logic [31:0] s, input int n, input logic [7:0] lead);
        int k;
        for (k = 0; k < n; k++)
            put(s[31-8*k -: 8]);
        put(CH_CR);
        get(lead);
        get(CH_C);
        get(CH_K);
        get(CH_CR);
        get(CH_CR);
        get(CH_COLON);
    endtask
    task automatic frame(input logic exp);
        @(posedge mclk_in);
        frame_ready <= 1'b1;
        @(posedge mclk_in);
        frame_ready <= 1'b0;
        @(negedge mclk_in);
        check("capture", {7'h00, capture}, {7'h00, exp});
    endtask
    // ****************
    // sequence
    // ****************
    initial
    begin
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(negedge mclk_in);
        check("hold", {7'h00, hold}, 8'h00);
        check("binary", {7'h00, binary}, 8'h00);
        get(CH_CR);
        get(CH_COLON);
        check("prompt", {7'h00, prompt_seen}, 8'h01);
        frame(1'b1);
        @(posedge mclk_in);
        stream_req <= 1'b1;
        @(posedge mclk_in);
        stream_req <= 1'b0;
        @(negedge mclk_in);
        check("stream", {7'h00, streaming}, 8'h01);
        cmd(32'h00000000, 0, CH_A);
        check("stream", {7'h00, streaming}, 8'h00);
        cmd({CH_B, CH_M, CH_SPACE, 8'h31}, 4, CH_A);
        check("hold", {7'h00, hold}, 8'h01);
        frame(1'b0);
        cmd({CH_R, CH_F, 16'h0000}, 2, CH_A);
        frame(1'b1);
        frame(1'b0);
        cmd({CH_R, CH_M, CH_SPACE, 8'h31}, 4, CH_A);
        check("binary", {7'h00, binary}, 8'h01);
        cmd(32'h58000000, 1, CH_N);
        check("hold", {7'h00, hold}, 8'h01);
        check("binary", {7'h00, binary}, 8'h01);
        finish_test();
    end
endmodule // tb_top
